// file: core/i2cs_regs.svh
`ifndef I2CS_REGS_SVH
`define I2CS_REGS_SVH

// ----------------------------------------------------------------------------
// mode field codes
// ----------------------------------------------------------------------------
`define I2CS_MODE_SLV7       4'h1
`define I2CS_MODE_SLV10      4'h2
`define I2CS_MODE_SLV7_SP    4'h3
`define I2CS_MODE_SLV10_SP   4'h4
`define I2CS_MODE_MASTER_CLK 4'h8
`define I2CS_MODE_FW_MASTER  4'h9

// ----------------------------------------------------------------------------
// protocol constants and reset values
// ----------------------------------------------------------------------------
`define I2CS_BITS_PER_BYTE   4'h8
`define I2CS_TEN_BIT_PREFIX  5'h1e
`define I2CS_RW_BIT          0
`define I2CS_OWN_ADDR_RESET  8'h00
`define I2CS_CLK_REL_RESET   1'h1
`define I2CS_LINE_IDLE       1'h1

`endif

// file: core/i2cs_pkg.sv
package i2cs_pkg;

  typedef enum logic [1:0] {
    I2CS_IDLE,
    I2CS_BITS,
    I2CS_ACK,
    I2CS_IGNORE
  } i2cs_phase_t;

  typedef struct packed {
    i2cs_phase_t phase;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic [7:0]  rx_buf;
    logic [7:0]  own_addr;
    logic        buf_full;
    logic        overflow;
    logic        irq;
    logic        addr_upd;
    logic        rd_wr;
    logic        clk_rel;
    logic        tx_mode;
    logic        tx_pend;
    logic        addr_byte;
    logic        addr_stage;
    logic        was_addr;
    logic        full_ok;
    logic        ack_drv;
    logic        ua_hold;
    logic        scl_pull;
    logic        scl_prev;
    logic        sda_prev;
    logic        start_det;
    logic        stop_det;
  } i2cs_state_t;

endpackage

// file: core/i2cs_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-stage level synchroniser; no reset because it carries only pin levels,
// which settle within two edges of the destination clock
module i2cs_sync #(
  parameter int WIDTH = 2
) (
  // clock
  input  wire logic             clk,
  // level in and out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } i2cs_sync_state_t;

  i2cs_sync_state_t st_q;
  i2cs_sync_state_t st_d;

  always_comb begin
    st_d        = st_q;
    st_d.meta   = async_in;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  assign sync_out = st_q.stable;

endmodule

`default_nettype wire

// file: core/i2cs_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2cs_regs.svh"

module i2cs_top
  import i2cs_pkg::*;
(
  // clocks and reset
  input  wire logic       CLOCK,
  input  wire logic       SYS_RST,
  input  wire logic       LINK_CLK,
  // bus pins, open drain
  input  wire logic       SCL_I,
  output logic            SCL_O,
  output logic            SCL_OE_N,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_N,
  // pin direction bits, high means input
  input  wire logic       PIN_DIR_SCL,
  input  wire logic       PIN_DIR_SDA,
  // configuration
  input  wire logic       PORT_ENABLE,
  input  wire logic [3:0] MODE,
  input  wire logic       STRETCH_ENABLE,
  // software strobes
  input  wire logic       CLOCK_RELEASE_SET,
  input  wire logic       OVERFLOW_CLR,
  input  wire logic       IRQ_CLR,
  input  wire logic       OWN_ADDR_WR,
  input  wire logic [7:0] OWN_ADDR_DATA,
  input  wire logic       BUF_RD,
  input  wire logic       BUF_WR,
  input  wire logic [7:0] BUF_WDATA,
  // status
  output logic [7:0]      BUF_RDATA,
  output logic [7:0]      OWN_ADDR,
  output logic            BUFFER_FULL,
  output logic            RECV_OVERFLOW,
  output logic            IRQ_FLAG,
  output logic            ADDR_UPDATE,
  output logic            READ_WRITE,
  output logic            CLOCK_RELEASE,
  output logic            START_SEEN,
  output logic            STOP_SEEN
);

  // --------------------------------------------------------------------------
  // mode decoding
  // --------------------------------------------------------------------------
  function automatic logic mode_is_slave(input logic [3:0] m);
    return (m == `I2CS_MODE_SLV7) || (m == `I2CS_MODE_SLV10) ||
           (m == `I2CS_MODE_SLV7_SP) || (m == `I2CS_MODE_SLV10_SP);
  endfunction

  function automatic logic mode_is_ten(input logic [3:0] m);
    return (m == `I2CS_MODE_SLV10) || (m == `I2CS_MODE_SLV10_SP);
  endfunction

  function automatic logic mode_has_sp(input logic [3:0] m);
    return (m == `I2CS_MODE_SLV7_SP) || (m == `I2CS_MODE_SLV10_SP);
  endfunction

  function automatic logic mode_is_twowire(input logic [3:0] m);
    return mode_is_slave(m) || (m == `I2CS_MODE_MASTER_CLK) ||
           (m == `I2CS_MODE_FW_MASTER);
  endfunction

  // 10-bit first byte must carry the fixed prefix as well as the stored high bits
  function automatic logic addr_match(input logic [7:0] sh, input logic [7:0] own,
                                      input logic ten, input logic stage);
    if (!ten) begin
      return sh[7:1] == own[7:1];
    end
    if (!stage) begin
      return (sh[7:3] == `I2CS_TEN_BIT_PREFIX) && (sh[7:1] == own[7:1]);
    end
    return sh == own;
  endfunction

  // --------------------------------------------------------------------------
  // pin sampling: link-clock stage, then system-clock stage
  // --------------------------------------------------------------------------
  logic [1:0] pins_link;
  logic [1:0] pins_sys;
  logic       scl_s;
  logic       sda_s;

  i2cs_sync #(.WIDTH(2)) u_sync_link (
    .clk      (LINK_CLK),
    .async_in ({SCL_I, SDA_I}),
    .sync_out (pins_link)
  );

  i2cs_sync #(.WIDTH(2)) u_sync_sys (
    .clk      (CLOCK),
    .async_in (pins_link),
    .sync_out (pins_sys)
  );

  assign scl_s = pins_sys[1];
  assign sda_s = pins_sys[0];

  // --------------------------------------------------------------------------
  // state and events
  // --------------------------------------------------------------------------
  localparam i2cs_state_t STATE_RESET = '{
    phase:    I2CS_IDLE,
    own_addr: `I2CS_OWN_ADDR_RESET,
    clk_rel:  `I2CS_CLK_REL_RESET,
    scl_prev: `I2CS_LINE_IDLE,
    sda_prev: `I2CS_LINE_IDLE,
    default:  '0
  };

  i2cs_state_t state_q;
  i2cs_state_t state_d;

  logic active;
  logic ten;
  logic pins_ok;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic hold_req;
  logic byte_done;
  logic accept_w;
  logic ninth_fall;
  logic nack_w;
  logic ua_set_w;
  logic match_w;

  assign active   = PORT_ENABLE && mode_is_slave(MODE);
  assign ten      = mode_is_ten(MODE);
  assign pins_ok  = PORT_ENABLE && mode_is_twowire(MODE) &&
                    PIN_DIR_SCL && PIN_DIR_SDA;
  assign scl_rise = scl_s && !state_q.scl_prev;
  assign scl_fall = !scl_s && state_q.scl_prev;
  assign start_ev = scl_s && state_q.scl_prev && state_q.sda_prev && !sda_s;
  assign stop_ev  = scl_s && state_q.scl_prev && !state_q.sda_prev && sda_s;
  assign hold_req = !state_q.clk_rel || state_q.ua_hold;
  assign accept_w = !state_q.buf_full && !state_q.overflow;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    state_d           = state_q;
    byte_done         = 1'h0;
    ninth_fall        = 1'h0;
    nack_w            = 1'h0;
    ua_set_w          = 1'h0;
    match_w           = 1'h0;
    state_d.scl_prev  = scl_s;
    state_d.sda_prev  = sda_s;
    state_d.start_det = 1'h0;
    state_d.stop_det  = 1'h0;

    // software clears come first so that a hardware set in the same cycle wins, except ua_hold, which is not set while OWN_ADDR_WR is high
    if (IRQ_CLR) begin
      state_d.irq = 1'h0;
    end
    if (OVERFLOW_CLR) begin
      state_d.overflow = 1'h0;
    end
    if (BUF_RD) begin
      state_d.buf_full = 1'h0;
    end
    if (OWN_ADDR_WR) begin
      state_d.own_addr = OWN_ADDR_DATA;
      state_d.addr_upd = 1'h0;
      state_d.ua_hold  = 1'h0;
    end
    if (BUF_WR && state_q.tx_mode) begin
      state_d.rx_buf   = BUF_WDATA;
      state_d.shift    = BUF_WDATA;
      state_d.buf_full = 1'h1;
    end
    if (CLOCK_RELEASE_SET) begin
      state_d.clk_rel = 1'h1;
    end

    if (!active) begin
      state_d.phase    = I2CS_IDLE;
      state_d.bit_cnt  = '0;
      state_d.ack_drv  = 1'h0;
      state_d.tx_mode  = 1'h0;
      state_d.tx_pend  = 1'h0;
      state_d.ua_hold  = 1'h0;
      state_d.full_ok  = 1'h0;
    end else if (start_ev) begin
      state_d.start_det  = 1'h1;
      state_d.phase      = I2CS_BITS;
      state_d.bit_cnt    = '0;
      state_d.addr_byte  = 1'h1;
      state_d.addr_stage = 1'h0;
      state_d.tx_mode    = 1'h0;
      state_d.tx_pend    = 1'h0;
      state_d.ack_drv    = 1'h0;
      if (mode_has_sp(MODE)) begin
        state_d.irq = 1'h1;
      end
    end else if (stop_ev) begin
      state_d.stop_det = 1'h1;
      state_d.phase    = I2CS_IDLE;
      state_d.full_ok  = 1'h0;
      state_d.tx_mode  = 1'h0;
      state_d.tx_pend  = 1'h0;
      state_d.ack_drv  = 1'h0;
      if (mode_has_sp(MODE)) begin
        state_d.irq = 1'h1;
      end
    end else begin
      case (state_q.phase)
        I2CS_BITS: begin
          if (scl_rise) begin
            state_d.bit_cnt = 4'(state_q.bit_cnt + 4'h1);
            if (!state_q.tx_mode) begin
              state_d.shift = {state_q.shift[6:0], sda_s};
            end
          end
          if (scl_fall && (state_q.bit_cnt != 4'h0)) begin
            if (state_q.tx_mode) begin
              state_d.shift = {state_q.shift[6:0], 1'h0};
            end
            if (state_q.bit_cnt == `I2CS_BITS_PER_BYTE) begin
              byte_done        = !state_q.tx_mode;
              state_d.phase    = I2CS_ACK;
              state_d.was_addr = state_q.addr_byte;
              if (state_q.tx_mode) begin
                state_d.buf_full = 1'h0;
              end else if (state_q.addr_byte) begin
                match_w = addr_match(state_q.shift, state_q.own_addr, ten,
                                     state_q.addr_stage);
                // a 10-bit read header only counts once the full address was seen
                if (ten && !state_q.addr_stage && state_q.shift[`I2CS_RW_BIT] &&
                    !state_q.full_ok) begin
                  match_w = 1'h0;
                end
                if (!match_w) begin
                  state_d.phase = I2CS_IGNORE;
                  byte_done     = 1'h0;
                end else begin
                  if (!state_q.addr_stage) begin
                    state_d.rd_wr   = state_q.shift[`I2CS_RW_BIT];
                    state_d.tx_pend = state_q.shift[`I2CS_RW_BIT];
                  end
                  if (ten && !state_q.shift[`I2CS_RW_BIT] && !state_q.addr_stage) begin
                    state_d.addr_upd   = 1'h1;
                    state_d.addr_stage = 1'h1;
                    ua_set_w           = 1'h1;
                  end else if (ten && state_q.addr_stage) begin
                    state_d.addr_upd  = 1'h1;
                    state_d.full_ok   = 1'h1;
                    state_d.addr_byte = 1'h0;
                    ua_set_w          = 1'h1;
                  end else begin
                    state_d.addr_byte = 1'h0;
                  end
                end
              end
              if (byte_done) begin
                if (accept_w) begin
                  state_d.rx_buf   = state_q.shift;
                  state_d.buf_full = 1'h1;
                  state_d.ack_drv  = 1'h1;
                end else if (state_q.buf_full) begin
                  state_d.overflow = 1'h1;
                end
              end
            end
          end
        end
        I2CS_ACK: begin
          if (scl_rise && state_q.tx_mode && sda_s) begin
            nack_w           = 1'h1;
            state_d.phase    = I2CS_IDLE;
            state_d.rd_wr    = 1'h0;
            state_d.addr_upd = 1'h0;
            state_d.buf_full = 1'h0;
            state_d.tx_mode  = 1'h0;
            state_d.irq      = 1'h1;
          end else if (scl_fall) begin
            ninth_fall      = 1'h1;
            state_d.ack_drv = 1'h0;
            state_d.irq     = 1'h1;
            state_d.phase   = I2CS_BITS;
            state_d.bit_cnt = '0;
            if (state_q.tx_pend) begin
              state_d.tx_mode = 1'h1;
              state_d.tx_pend = 1'h0;
              if (!CLOCK_RELEASE_SET) begin
                state_d.clk_rel = 1'h0;
              end
            end else if (state_q.tx_mode) begin
              if (!state_q.buf_full && !CLOCK_RELEASE_SET) begin
                state_d.clk_rel = 1'h0;
              end
            end else if (state_q.addr_upd && !OWN_ADDR_WR) begin
              state_d.ua_hold = 1'h1;
            end else if (STRETCH_ENABLE && state_q.buf_full && !CLOCK_RELEASE_SET &&
                         !(ten && state_q.was_addr)) begin
              state_d.clk_rel = 1'h0;
            end
          end
        end
        I2CS_IDLE, I2CS_IGNORE: begin
        end
        default: begin
          state_d.phase = I2CS_IDLE;
        end
      endcase
    end

    // only pull once the master has already pulled the line low
    if (active && hold_req) begin
      state_d.scl_pull = state_q.scl_pull || !scl_s;
    end else begin
      state_d.scl_pull = 1'h0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state_q <= STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  logic sda_pull;

  assign sda_pull = state_q.ack_drv ||
                    ((state_q.phase == I2CS_BITS) && state_q.tx_mode && !state_q.shift[7]);

  assign SCL_O         = 1'h0;
  assign SDA_O         = 1'h0;
  assign SCL_OE_N      = !(pins_ok && state_q.scl_pull);
  assign SDA_OE_N      = !(pins_ok && sda_pull);
  assign BUF_RDATA     = state_q.rx_buf;
  assign OWN_ADDR      = state_q.own_addr;
  assign BUFFER_FULL   = state_q.buf_full;
  assign RECV_OVERFLOW = state_q.overflow;
  assign IRQ_FLAG      = state_q.irq;
  assign ADDR_UPDATE   = state_q.addr_upd;
  assign READ_WRITE    = state_q.rd_wr;
  assign CLOCK_RELEASE = state_q.clk_rel;
  assign START_SEEN    = state_q.start_det;
  assign STOP_SEEN     = state_q.stop_det;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  AST_DISABLED_IDLE: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !PORT_ENABLE |=> (state_q.phase == I2CS_IDLE) && SCL_OE_N && SDA_OE_N)
    else $error("block not idle while disabled");

  AST_DIR_GATE: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (!PIN_DIR_SCL || !PIN_DIR_SDA) |-> SCL_OE_N && SDA_OE_N)
    else $error("pin driven while direction is output");

  AST_ACK_LOAD: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (byte_done && accept_w) |=> state_q.buf_full && state_q.ack_drv &&
                                (state_q.rx_buf == $past(state_q.shift)))
    else $error("accepted byte not loaded and acknowledged");

  AST_REFUSE_FULL: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (byte_done && !accept_w) |=> !state_q.ack_drv &&
                                 (state_q.rx_buf == $past(state_q.rx_buf)) ##1 1'h1)
    else $error("refused byte was acknowledged or loaded");

  AST_OVF_SET: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (byte_done && state_q.buf_full) |=> state_q.overflow)
    else $error("overflow not raised on byte into full buffer");

  AST_IRQ_NINTH: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    ninth_fall |=> state_q.irq && !state_q.ack_drv && (state_q.phase == I2CS_BITS))
    else $error("interrupt flag not set on ninth falling edge");

  AST_READ_HOLD: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (ninth_fall && state_q.tx_pend && !CLOCK_RELEASE_SET) |=>
      !state_q.clk_rel && state_q.tx_mode)
    else $error("read address did not hold the clock");

  AST_RX_STRETCH: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (ninth_fall && !state_q.tx_mode && !state_q.tx_pend && !ten && STRETCH_ENABLE &&
     state_q.buf_full && !CLOCK_RELEASE_SET) |=> !state_q.clk_rel)
    else $error("receive stretch missing with buffer full");

  AST_PULL_WHEN_LOW: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    $rose(state_q.scl_pull) |-> !$past(scl_s) && $past(hold_req))
    else $error("clock pulled while line was high");

  AST_NACK_RESET: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    nack_w |=> (state_q.phase == I2CS_IDLE) && !state_q.rd_wr && !state_q.buf_full)
    else $error("no-acknowledge did not reset slave logic");

  AST_UA_CLEAR: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (OWN_ADDR_WR && !ua_set_w) |=> !state_q.addr_upd && !state_q.ua_hold &&
                                   (state_q.own_addr == $past(OWN_ADDR_DATA)))
    else $error("address write did not clear address update");

endmodule

`default_nettype wire

// file: dv/i2cs_master.sv
`timescale 1ns/1ps
`default_nettype none

// bus master model; both lines are wired-and with pull-ups, so a released
// line reads high rather than holding its last value
module i2cs_master (
  // device pull enables, active low
  input  wire logic scl_oe_n,
  input  wire logic sda_oe_n,
  // resolved wire levels
  output logic      scl,
  output logic      sda
);
  localparam int T = 1000;
  logic scl_m = 1'b1;
  logic sda_m = 1'b1;

  assign scl = scl_m & scl_oe_n;
  assign sda = sda_m & sda_oe_n;

  // ----------------------------------------------------------------------
  // bit, byte and framing
  // ----------------------------------------------------------------------
  // data moves only while the clock is low; a stretched clock is waited on,
  // with a bound so a stuck device cannot hang the run
  task automatic bit_x(input logic b, output logic r);
    sda_m = b;
    #T scl_m = 1'b1;
    for (int i = 0; i < 3000 && !scl; i++) #100;
    #T r = sda;
    scl_m = 1'b0;
    #T;
  endtask

  task automatic xfer(input logic [7:0] d, input logic am, output logic [7:0] q,
                      output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q = {q[6:0], r};
    end
    bit_x(am, a);
  endtask

  task automatic start();
    sda_m = 1'b1;
    scl_m = 1'b1;
    #T sda_m = 1'b0;
    #T scl_m = 1'b0;
    #T;
  endtask

  task automatic stop();
    sda_m = 1'b0;
    #T scl_m = 1'b1;
    #T sda_m = 1'b1;
    #T;
  endtask
endmodule

`default_nettype wire

// file: dv/i2cs_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module i2cs_top_tb_top;
  logic       clock = 1'b0;
  logic       lclk  = 1'b0;
  logic       rst   = 1'b1;
  logic       pen   = 1'b1;
  logic       sten  = 1'b1;
  logic [3:0] mode  = 4'h1;
  logic       crs = 1'b0, ovc = 1'b0, irc = 1'b0, oaw = 1'b0, brd = 1'b0, bwr = 1'b0;
  logic [7:0] oad = 8'h00, bwd = 8'h00, q;
  logic       a;
  wire logic  scl, sda, scl_oe_n, sda_oe_n, full, ovf, irq, ua, rw, crel;
  wire logic [7:0] rdata, oaddr;
  wire logic  st_s, sp_s;
  int n_fail = 0, tests_run = 0, cyc = 0;
  int n_start = 0, n_stop = 0;

  // the pulses stand a whole cycle, so the falling edge sees them settled
  always @(negedge clock) begin
    if (st_s) n_start++;
    if (sp_s) n_stop++;
  end

  always #50 clock = ~clock;
  always #32 lclk = ~lclk;

  i2cs_top i2cs_top_inst (
    .CLOCK(clock), .SYS_RST(rst), .LINK_CLK(lclk),
    .SCL_I(scl), .SCL_O(), .SCL_OE_N(scl_oe_n),
    .SDA_I(sda), .SDA_O(), .SDA_OE_N(sda_oe_n),
    .PIN_DIR_SCL(1'b1), .PIN_DIR_SDA(1'b1),
    .PORT_ENABLE(pen), .MODE(mode), .STRETCH_ENABLE(sten),
    .CLOCK_RELEASE_SET(crs), .OVERFLOW_CLR(ovc), .IRQ_CLR(irc),
    .OWN_ADDR_WR(oaw), .OWN_ADDR_DATA(oad), .BUF_RD(brd), .BUF_WR(bwr),
    .BUF_WDATA(bwd), .BUF_RDATA(rdata), .OWN_ADDR(oaddr), .BUFFER_FULL(full),
    .RECV_OVERFLOW(ovf), .IRQ_FLAG(irq), .ADDR_UPDATE(ua), .READ_WRITE(rw),
    .CLOCK_RELEASE(crel), .START_SEEN(st_s), .STOP_SEEN(sp_s)
  );

  i2cs_master i2cs_master_inst (
    .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda)
  );

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic ck(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one-cycle strobe, plus a cycle for the registered answer to settle
  task automatic pl(ref logic s);
    @(negedge clock) s = 1'b1;
    @(negedge clock) s = 1'b0;
    @(negedge clock);
  endtask

  task automatic wa(input logic [7:0] d);
    @(negedge clock) oad = d;
    pl(oaw);
  endtask

  task automatic tx(input logic [7:0] d);
    @(negedge clock) bwd = d;
    pl(bwr);
    pl(crs);
  endtask

  task automatic wb(input logic [7:0] d);
    i2cs_master_inst.xfer(d, 1'b1, q, a);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_write();
    i2cs_master_inst.start();
    wb(8'ha0);
    ck(a, 16'h0000);
    ck(rdata, 16'h00a0);
    ck({full, rw, irq}, 16'h0005);
    ck({crel, scl_oe_n}, 16'h0000);
    pl(brd);
    pl(irc);
    ck({full, irq}, 16'h0000);
    pl(crs);
    ck(scl_oe_n, 16'h0001);
    wb(8'h5a);
    ck({a, irq, rdata}, 16'h015a);
    pl(crs);
    wb(8'h33);
    ck({a, rdata}, 16'h015a);
    ck({ovf, irq}, 16'h0003);
    pl(ovc);
    pl(brd);
    pl(irc);
    pl(crs);
    ck({ovf, full}, 16'h0000);
    i2cs_master_inst.stop();
    ck({n_start[7:0], n_stop[7:0]}, 16'h0101);
  endtask

  task automatic t_read();
    @(negedge clock) sten = 1'b0;
    i2cs_master_inst.start();
    wb(8'ha1);
    ck({a, rw, crel, scl_oe_n}, 16'h0004);
    pl(brd);
    pl(irc);
    tx(8'hc3);
    i2cs_master_inst.xfer(8'hff, 1'b0, q, a);
    ck(q, 16'h00c3);
    ck({irq, crel, full}, 16'h0004);
    pl(irc);
    tx(8'h96);
    i2cs_master_inst.xfer(8'hff, 1'b1, q, a);
    ck(q, 16'h0096);
    ck({rw, full, irq}, 16'h0001);
    pl(irc);
    i2cs_master_inst.stop();
  endtask

  task automatic t_miss();
    i2cs_master_inst.start();
    wb(8'h42);
    ck({a, irq}, 16'h0002);
    i2cs_master_inst.stop();
    @(negedge clock) mode = 4'h3;
    i2cs_master_inst.start();
    wb(8'h42);
    ck({a, irq}, 16'h0003);
    pl(irc);
    i2cs_master_inst.stop();
    ck(irq, 16'h0001);
    pl(irc);
    @(negedge clock) mode = 4'h8;
    i2cs_master_inst.start();
    wb(8'ha0);
    ck({a, full}, 16'h0002);
    i2cs_master_inst.stop();
    @(negedge clock) mode = 4'h1;
    pen = 1'b0;
    i2cs_master_inst.start();
    wb(8'ha0);
    ck({a, full}, 16'h0002);
    i2cs_master_inst.stop();
    @(negedge clock) pen = 1'b1;
  endtask

  task automatic t_ten();
    @(negedge clock) mode = 4'h2;
    sten = 1'b1;
    wa(8'hf2);
    i2cs_master_inst.start();
    wb(8'hf2);
    ck({a, ua, scl_oe_n, crel}, 16'h0005);
    pl(brd);
    pl(irc);
    wa(8'h34);
    ck({ua, scl_oe_n, oaddr}, 16'h0134);
    wb(8'h34);
    ck({a, ua, rdata}, 16'h0134);
    pl(brd);
    pl(irc);
    wa(8'hf2);
    i2cs_master_inst.stop();
  endtask

  // the ceiling sits well above the few thousand cycles the scenarios need
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (16) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    ck({crel, sda_oe_n, scl_oe_n}, 16'h0007);
    wa(8'ha0);
    t_write();
    t_read();
    t_miss();
    t_ten();
    tally_and_finish();
  end
endmodule

`default_nettype wire
